// ==== design/sfp_flash.sv ====
// Serial flash command logic: identifier read, page program, bulk and sector
// erase, status poll and power state. The host drives all pins asynchronously.
//
// Contract
// - Identifier opcode returns 8-bit code serially
// - Identifier read ignored during busy cycle
// - Opcode, three dummy bytes, then falling-edge output
// - Identifier repeats while select stays low
// - Page program opcode needs write latch set
// - Page data wraps at 256-byte boundary
// - Over 256 bytes: last 256 kept
// - Fewer bytes: rest of page untouched
// - Select must rise on byte boundary
// - Write latch cleared before program completes
// - Program cycle starts at select rise
// - Busy bit high during program, polls allowed
// - Bulk erase sets all bits to one
// - Bulk erase self-timed from select rise
// - Erase shows busy and clears write latch
// - Sector erase fills selected sector with ones
// - Any address inside sector selects it
// - Sector erase self-timed from select rise
// - Active while selected or busy, else standby
// - Upper address bits beyond capacity ignored
// - Busy flag sits in status bit zero
// - Sample input rising, drive output falling
// - No program or erase with latch clear
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Staging FIFO between the serial front end and the page buffer.
module sfp_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             nrst,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   cnt;
	} sfp_fifo_s;

	sfp_fifo_s         st;
	sfp_fifo_s         next_st;
	logic [WIDTH-1:0]  mem [DEPTH];
	logic              push;
	logic              pop;

	assign in_ready  = (st.cnt != (AW+1)'(DEPTH));
	assign out_valid = (st.cnt != '0);
	assign out_data  = mem[st.rp];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		next_st = st;
		if (push)
			next_st.wp = st.wp + 1'b1;
		if (pop)
			next_st.rp = st.rp + 1'b1;
		next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge mclk) begin
		if (!nrst)
			st <= '0;
		else
			st <= next_st;
		if (push)
			mem[st.wp] <= in_data;
	end
endmodule : sfp_fifo

////////////////////////////////////////////////////////////////////////////////
// Top: pin synchronisers, serial decoder, page buffer, array and timer.
module sfp_flash #(
	parameter int PROG_CYCLES   = sfp_pkg::PROG_CYC,
	parameter int BULK_CYCLES   = sfp_pkg::BULK_CYC,
	parameter int SECTOR_CYCLES = sfp_pkg::SECTOR_CYC
) (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic nrst,
	// Serial pins from the host
	input  wire logic chip_select_n,
	input  wire logic serial_clock_in,
	input  wire logic serial_cmd_in,
	// Serial output pin, enable low while driving
	output logic      serial_data_out,
	output logic      serial_data_oe_n,
	// Power state
	output logic      active_power
);
	localparam int AW = sfp_pkg::ADDR_W;
	localparam int BW = 32;

	typedef struct packed {
		logic [2:0]              cs_s;
		logic [2:0]              ck_s;
		logic [2:0]              di_s;
		sfp_pkg::sfp_phase_e     phase;
		logic [7:0]              op;
		logic [7:0]              shreg;
		logic [2:0]              bitn;
		logic [1:0]              bytes;
		logic [23:0]             addr;
		logic [7:0]              outreg;
		logic                    dout;
		logic                    oe_n;
		logic                    wel;
		logic                    busy;
		logic                    armed;
		logic                    sect_sel;
		sfp_pkg::sfp_job_e       job;
		logic [BW-1:0]           timer;
		logic [sfp_pkg::PAGE_W:0] widx;
		logic                    act;
	} sfp_core_s;

	sfp_core_s         st;
	sfp_core_s         next_st;
	logic [7:0]        pbuf [256];
	logic [255:0]      pmask;
	logic [7:0]        array [1 << AW];
	logic              cs_n;
	logic              ck_rise;
	logic              ck_fall;
	logic              din;
	logic              byte_done;
	logic [7:0]        byte_val;
	logic              f_in_valid;
	logic              f_in_ready;
	logic [15:0]       f_in_data;
	logic              f_out_valid;
	logic [15:0]       f_out_data;
	logic              commit;

	function automatic logic [7:0] status_byte(input logic busy, input logic wel);
		status_byte = 8'h0000;
		status_byte[sfp_pkg::ST_BUSY] = busy;
		status_byte[sfp_pkg::ST_WEL]  = wel;
	endfunction : status_byte

	// The second stage of each synchroniser is read by the logic below; the clock edge detect also reads the third.
	assign cs_n      = st.cs_s[1];
	assign ck_rise   = st.ck_s[1] && !st.ck_s[2];
	assign ck_fall   = !st.ck_s[1] && st.ck_s[2];
	assign din       = st.di_s[1];
	assign byte_val  = {st.shreg[6:0], din};
	assign byte_done = ck_rise && !cs_n && (st.bitn == 3'd7);
	assign f_in_valid = byte_done && (st.phase == sfp_pkg::SFP_DATA);
	assign f_in_data  = {st.addr[7:0], byte_val};
	// Commit waits one cycle after the select rise so that the armed flag has
	// settled, and until the staging FIFO has drained into the page buffer.
	assign commit     = st.armed && cs_n && (st.phase == sfp_pkg::SFP_IDLE) && !f_out_valid;

	sfp_fifo #(.WIDTH(16), .DEPTH(sfp_pkg::FIFO_DEPTH)) u_fifo (
		.mclk      (mclk),
		.nrst      (nrst),
		.in_valid  (f_in_valid),
		.in_ready  (f_in_ready),
		.in_data   (f_in_data),
		.out_valid (f_out_valid),
		.out_ready (1'b1),
		.out_data  (f_out_data)
	);

	always_comb begin
		next_st = st;
		// First stage feeds only the second; the second feeds the logic and, for the clock, the edge detect.
		next_st.cs_s = {st.cs_s[1:0], chip_select_n};
		next_st.ck_s = {st.ck_s[1:0], serial_clock_in};
		next_st.di_s = {st.di_s[1:0], serial_cmd_in};

		if (cs_n) begin
			// A rise mid-byte in a data phase cancels the program.
			// Bulk erase arms only when select rises straight after its opcode.
			next_st.armed = (st.phase == sfp_pkg::SFP_DATA && st.bitn == 3'd0
				&& st.widx != '0) || (st.phase == sfp_pkg::SFP_ADDR
				&& st.job == sfp_pkg::SFP_OP_ERAS && st.bytes == 2'd3
				&& st.bitn == 3'd0) || (st.phase == sfp_pkg::SFP_SKIP
				&& st.job == sfp_pkg::SFP_OP_ERAS && st.bitn == 3'd0
				&& st.op == sfp_pkg::OP_BULK_ER);
			if (st.phase == sfp_pkg::SFP_IDLE)
				next_st.armed = st.armed;
			next_st.phase = sfp_pkg::SFP_IDLE;
			next_st.bitn  = '0;
			next_st.bytes = '0;
			next_st.oe_n  = 1'b1;
		end else if (ck_rise) begin
			next_st.shreg = byte_val;
			next_st.bitn  = st.bitn + 3'd1;
			if (st.phase == sfp_pkg::SFP_IDLE) begin
				next_st.phase = sfp_pkg::SFP_OPCODE;
				next_st.widx  = '0;
				next_st.armed = 1'b0;
			end
			if (byte_done) begin
				unique case (st.phase)
					sfp_pkg::SFP_IDLE, sfp_pkg::SFP_OPCODE: begin
						next_st.op    = byte_val;
						next_st.phase = sfp_pkg::SFP_SKIP;
						next_st.job   = sfp_pkg::SFP_OP_NONE;
						if (byte_val == sfp_pkg::OP_RD_STATUS) begin
							next_st.outreg = status_byte(st.busy, st.wel);
							next_st.phase  = sfp_pkg::SFP_SHOUT;
						end else if (!st.busy) begin
							if (byte_val == sfp_pkg::OP_WR_ENABLE)
								next_st.wel = 1'b1;
							else if (byte_val == sfp_pkg::OP_READ_ID)
								next_st.phase = sfp_pkg::SFP_ADDR;
							else if (st.wel && (byte_val == sfp_pkg::OP_PROGRAM)) begin
								next_st.phase = sfp_pkg::SFP_ADDR;
								next_st.job   = sfp_pkg::SFP_OP_PROG;
							end else if (st.wel && (byte_val == sfp_pkg::OP_SECTOR_ER)) begin
								next_st.phase    = sfp_pkg::SFP_ADDR;
								next_st.job      = sfp_pkg::SFP_OP_ERAS;
								next_st.sect_sel = 1'b1;
							end else if (st.wel && (byte_val == sfp_pkg::OP_BULK_ER)) begin
								next_st.job      = sfp_pkg::SFP_OP_ERAS;
								next_st.sect_sel = 1'b0;
							end
						end
					end
					sfp_pkg::SFP_ADDR: begin
						next_st.addr  = {st.addr[15:0], byte_val};
						next_st.bytes = st.bytes + 2'd1;
						if (st.bytes == 2'(sfp_pkg::DUMMY_BYTES - 1)) begin
							if (st.op == sfp_pkg::OP_READ_ID) begin
								next_st.outreg = sfp_pkg::ID_CODE;
								next_st.phase  = sfp_pkg::SFP_SHOUT;
							end else if (st.job == sfp_pkg::SFP_OP_PROG)
								next_st.phase = sfp_pkg::SFP_DATA;
							next_st.bytes = (st.job == sfp_pkg::SFP_OP_ERAS) ? 2'd3 : 2'd0;
						end
					end
					sfp_pkg::SFP_DATA: begin
						next_st.addr[7:0] = st.addr[7:0] + 8'd1;
						if (st.widx != 9'd256 && f_in_ready)
							next_st.widx = st.widx + 9'd1;
					end
					sfp_pkg::SFP_SHOUT: begin
					end
					// Any byte after the bulk erase opcode cancels the erase.
					sfp_pkg::SFP_SKIP: begin
						next_st.job = sfp_pkg::SFP_OP_NONE;
					end
				endcase
			end
		end else if (ck_fall && st.phase == sfp_pkg::SFP_SHOUT) begin
			next_st.oe_n   = 1'b0;
			next_st.dout   = st.outreg[7];
			// Rotating repeats the identifier on every further byte.
			next_st.outreg = {st.outreg[6:0], st.outreg[7]};
			// A continued status read reloads the live status at each byte boundary
			// and sends its top bit at once, so the byte framing stays intact.
			if (st.op == sfp_pkg::OP_RD_STATUS && st.bitn == 3'd0 && st.oe_n == 1'b0) begin
				next_st.outreg = status_byte(st.busy, st.wel);
				next_st.dout   = next_st.outreg[7];
				next_st.outreg = {next_st.outreg[6:0], next_st.outreg[7]};
			end
		end

		// Busy is raised in the same cycle as the array update, so a status poll can
		// never see the new contents with busy still low.
		if (commit) begin
			next_st.armed = 1'b0;
			next_st.busy  = 1'b1;
			next_st.wel   = 1'b0;
			unique case (st.job)
				sfp_pkg::SFP_OP_PROG: next_st.timer = BW'(PROG_CYCLES);
				sfp_pkg::SFP_OP_ERAS: next_st.timer = st.sect_sel ? BW'(SECTOR_CYCLES)
					: BW'(BULK_CYCLES);
				default: next_st.busy = 1'b0;
			endcase
		end else if (st.busy) begin
			next_st.timer = st.timer - BW'(1);
			if (st.timer == BW'(1))
				next_st.busy = 1'b0;
		end
		// Built from next values so that the gap between the select rise and the
		// start of a self-timed cycle never shows as a short standby.
		next_st.act = !cs_n || next_st.armed || next_st.busy;
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			st       <= '0;
			st.cs_s  <= 3'b111;
			st.phase <= sfp_pkg::SFP_IDLE;
			st.job   <= sfp_pkg::SFP_OP_NONE;
			st.oe_n  <= 1'b1;
		end else
			st <= next_st;
	end

	// Page buffer: a new program clears the mask; later bytes overwrite earlier.
	always_ff @(posedge mclk) begin
		if (!nrst || (ck_rise && !cs_n && st.phase == sfp_pkg::SFP_IDLE))
			pmask <= '0;
		else if (f_out_valid) begin
			pbuf[f_out_data[15:8]]  <= f_out_data[7:0];
			pmask[f_out_data[15:8]] <= 1'b1;
		end
	end

	// Array update happens at commit; timing is then modelled by the busy timer.
	always_ff @(posedge mclk) begin
		if (commit && st.job == sfp_pkg::SFP_OP_PROG) begin
			for (int i = 0; i < 256; i++)
				if (pmask[i])
					array[{st.addr[AW-1:sfp_pkg::PAGE_W], 8'(i)}] <=
						array[{st.addr[AW-1:sfp_pkg::PAGE_W], 8'(i)}] & pbuf[i];
		end else if (commit && st.job == sfp_pkg::SFP_OP_ERAS) begin
			for (int j = 0; j < (1 << AW); j++)
				if (!st.sect_sel || (j[AW-1:sfp_pkg::SECTOR_LO]
					== st.addr[AW-1:sfp_pkg::SECTOR_LO]))
					array[j] <= sfp_pkg::ERASED;
		end
	end

	assign serial_data_out  = st.dout;
	assign serial_data_oe_n = st.oe_n;
	assign active_power     = st.act;
endmodule : sfp_flash

`default_nettype wire

// ==== inc/sfp_pkg.sv ====
// Constants and types for the serial flash program and erase command logic.
// Assumes a 200 MHz system clock and a host-driven serial clock far below it.
package sfp_pkg;

	// Opcodes, most significant bit first.
	localparam logic [7:0] OP_READ_ID   = 8'h00AB;
	localparam logic [7:0] OP_PROGRAM   = 8'h0002;
	localparam logic [7:0] OP_BULK_ER   = 8'h00C7;
	localparam logic [7:0] OP_SECTOR_ER = 8'h00D8;
	localparam logic [7:0] OP_WR_ENABLE = 8'h0006;
	localparam logic [7:0] OP_RD_STATUS = 8'h0005;

	// Identification code; the value is arbitrary.
	localparam logic [7:0] ID_CODE = 8'h005A;

	// Array geometry: 19 significant address bits, 64 KiB sectors.
	localparam int ADDR_W    = 19;
	localparam int SECTOR_LO = 16;
	localparam int PAGE_W    = 8;
	localparam int DUMMY_BYTES = 3;

	// Status register bit positions.
	localparam int ST_BUSY = 0;
	localparam int ST_WEL  = 1;

	// Erased byte value.
	localparam logic [7:0] ERASED = 8'h00FF;

	// Cycle times of the self-timed operations.
	localparam real CLK_MHZ      = 200.0;
	localparam real T_PROG_US    = 1500.0;
	localparam real T_BULK_MS    = 5000.0;
	localparam real T_SECTOR_MS  = 2000.0;
	localparam int  PROG_CYC     = int'(T_PROG_US * CLK_MHZ);
	localparam int  BULK_CYC     = int'(T_BULK_MS * 1000.0 * CLK_MHZ);
	localparam int  SECTOR_CYC   = int'(T_SECTOR_MS * 1000.0 * CLK_MHZ);

	// Staging FIFO shape.
	localparam int FIFO_DEPTH = 4;

	typedef enum logic [5:0] {
		SFP_IDLE   = 6'b00_0001,
		SFP_OPCODE = 6'b00_0010,
		SFP_ADDR   = 6'b00_0100,
		SFP_DATA   = 6'b00_1000,
		SFP_SHOUT  = 6'b01_0000,
		SFP_SKIP   = 6'b10_0000
	} sfp_phase_e;

	typedef enum logic [2:0] {
		SFP_OP_NONE = 3'b001,
		SFP_OP_PROG = 3'b010,
		SFP_OP_ERAS = 3'b100
	} sfp_job_e;

endpackage : sfp_pkg

// ==== sim/sfp_flash_properties.sv ====
// Port-level checker for the serial flash command logic.
// Assumes the host keeps select low across whole frames with an idle serial clock.
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////
module sfp_flash_properties (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Pins
	input wire logic chip_select_n,
	input wire logic serial_clock_in,
	input wire logic serial_cmd_in,
	input wire logic serial_data_out,
	input wire logic serial_data_oe_n,
	input wire logic active_power
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	logic       sclk_q;
	logic [7:0] since_fall;
	logic [5:0] rises;
	// Both counters saturate so that long idle stretches cannot wrap them.
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			sclk_q     <= 1'b0;
			since_fall <= 8'h00FF;
			rises      <= 6'h00;
		end else begin
			sclk_q     <= serial_clock_in;
			since_fall <= (sclk_q && !serial_clock_in) ? 8'h0000
				: (since_fall == 8'h00FF) ? since_fall : since_fall + 8'h0001;
			rises      <= chip_select_n ? 6'h00
				: (!sclk_q && serial_clock_in && rises != 6'h3F) ? rises + 6'h01 : rises;
		end
	end
	property p_active_sel; !chip_select_n [*5] |-> active_power; endproperty
	a_active_sel: assert property (p_active_sel) else $error("not active while selected");
	property p_fell_active; $fell(active_power) |-> $past(chip_select_n, 2); endproperty
	a_fell_active: assert property (p_fell_active) else $error("standby while selected");
	property p_rose_active; $rose(active_power) |-> !$past(chip_select_n, 2); endproperty
	a_rose_active: assert property (p_rose_active) else $error("active without select");
	property p_oe_idle; chip_select_n [*4] |-> serial_data_oe_n; endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("output driven while deselected");
	property p_oe_quick; $rose(chip_select_n) |-> ##[1:4] serial_data_oe_n; endproperty
	a_oe_quick: assert property (p_oe_quick) else $error("output not released");
	property p_oe_cmd; !serial_data_oe_n && !chip_select_n |-> rises >= 6'd8; endproperty
	a_oe_cmd: assert property (p_oe_cmd) else $error("output before opcode");
	property p_oe_edge; $fell(serial_data_oe_n) |-> since_fall <= 8'd8; endproperty
	a_oe_edge: assert property (p_oe_edge) else $error("output start off falling edge");
	property p_out_edge;
		!chip_select_n && !serial_data_oe_n && $changed(serial_data_out) |-> since_fall <= 8'd8;
	endproperty
	a_out_edge: assert property (p_out_edge) else $error("output bit off falling edge");
	c_drive: cover property ($fell(serial_data_oe_n));
	c_busy: cover property ((chip_select_n && active_power) [*8]);
	c_standby: cover property ($fell(active_power));
endmodule : sfp_flash_properties
bind sfp_flash sfp_flash_properties u_props (.mclk(mclk), .nrst(nrst),
	.chip_select_n(chip_select_n), .serial_clock_in(serial_clock_in),
	.serial_cmd_in(serial_cmd_in), .serial_data_out(serial_data_out),
	.serial_data_oe_n(serial_data_oe_n), .active_power(active_power));
`default_nettype wire

// ==== sim/sfp_host_model.sv ====
// Host model: drives select, a 125 ns serial clock and command bits.
// Assumes a 5 ns mclk; all pin changes follow a rising mclk edge.
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////
module sfp_host_model (
	// Clock
	input wire logic mclk,
	// Serial pins
	output logic      chip_select_n,
	output logic      serial_clock_in,
	output logic      serial_cmd_in,
	input wire logic  serial_data_out,
	input wire logic  serial_data_oe_n
);
	logic drove;
	wire logic data_pin;
	// A released pin reads inverted so a stale bit never passes for data.
	assign data_pin = serial_data_out ^ serial_data_oe_n;
	initial begin
		chip_select_n   = 1'b1;
		serial_clock_in = 1'b0;
		serial_cmd_in   = 1'b0;
		drove           = 1'b0;
	end
	task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i >= 8 - n; i--) begin
			serial_cmd_in <= tx[i];
			repeat (12) @(posedge mclk);
			rx[i] = data_pin;
			drove |= ~serial_data_oe_n;
			serial_clock_in <= 1'b1;
			repeat (13) @(posedge mclk);
			serial_clock_in <= 1'b0;
		end
	endtask : xfer
	task automatic open_frame;
		@(posedge mclk);
		chip_select_n <= 1'b0;
		drove = 1'b0;
		repeat (6) @(posedge mclk);
	endtask : open_frame
	task automatic close_frame;
		repeat (6) @(posedge mclk);
		chip_select_n <= 1'b1;
		repeat (24) @(posedge mclk);
	endtask : close_frame
endmodule : sfp_host_model
`default_nettype wire

// ==== sim/tb_sfp_flash.sv ====
// Self-checking bench for the serial flash command logic.
// Assumes shortened busy timers; status bit 0 busy, bit 1 write latch.
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////
module tb_sfp_flash;
	logic       mclk, nrst, cs_n, sclk, sdi, sdo, oe_n, act;
	logic [7:0] s, a, b;
	logic [7:0] codes [3] = '{sfp_pkg::OP_PROGRAM, sfp_pkg::OP_BULK_ER, sfp_pkg::OP_SECTOR_ER};
	int         nadr [3] = '{3, 0, 3};
	int         err_total, comparisons, seed, cycles;
	sfp_flash #(.PROG_CYCLES(2000), .BULK_CYCLES(1200), .SECTOR_CYCLES(1100)) u_dut (
		.mclk(mclk), .nrst(nrst), .chip_select_n(cs_n), .serial_clock_in(sclk),
		.serial_cmd_in(sdi), .serial_data_out(sdo), .serial_data_oe_n(oe_n),
		.active_power(act));
	sfp_host_model u_host (.mclk(mclk), .chip_select_n(cs_n), .serial_clock_in(sclk),
		.serial_cmd_in(sdi), .serial_data_out(sdo), .serial_data_oe_n(oe_n));
	always #2.5 mclk = ~mclk;
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	function automatic logic [7:0] exp_status(input logic busy, input logic wel);
		exp_status = 8'h00;
		exp_status[sfp_pkg::ST_BUSY] = busy;
		exp_status[sfp_pkg::ST_WEL]  = wel;
	endfunction : exp_status
	task automatic tx(input logic [7:0] v);
		u_host.xfer(v, 8, a);
	endtask : tx
	task automatic status(output logic [7:0] r);
		u_host.open_frame();
		tx(sfp_pkg::OP_RD_STATUS);
		u_host.xfer(8'h00, 8, r);
		u_host.close_frame();
	endtask : status
	task automatic op(input logic [7:0] code, input int na, input int nd);
		u_host.open_frame();
		tx(code);
		repeat (na + nd) tx(8'($random(seed)));
		u_host.close_frame();
	endtask : op
	task automatic read_id;
		u_host.open_frame();
		tx(sfp_pkg::OP_READ_ID);
		repeat (sfp_pkg::DUMMY_BYTES) tx(8'($random(seed)));
		u_host.xfer(8'h00, 8, a);
		u_host.xfer(8'h00, 8, b);
		u_host.close_frame();
	endtask : read_id
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : close_out
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 60000) begin
			err_total++;
			close_out();
		end
	end
	initial begin
		mclk = 1'b0;
		nrst = 1'b0;
		seed = 19947;
		repeat (5) @(posedge mclk);
		nrst <= 1'b1;
		repeat (4) @(posedge mclk);
		status(s);
		chk(s, 8'h00);
		read_id();
		chk(a, sfp_pkg::ID_CODE);
		chk(b, sfp_pkg::ID_CODE);
		$display("test identifier done");
		op(sfp_pkg::OP_PROGRAM, 3, 2);
		status(s);
		chk(s, 8'h00);
		$display("test latch clear done");
		for (int k = 0; k < 3; k++) begin
			op(sfp_pkg::OP_WR_ENABLE, 0, 0);
			u_host.open_frame();
			tx(sfp_pkg::OP_RD_STATUS);
			u_host.xfer(8'h00, 8, s);
			u_host.xfer(8'h00, 8, b);
			u_host.close_frame();
			chk(s, exp_status(1'b0, 1'b1));
			chk(b, exp_status(1'b0, 1'b1));
			op(codes[k], nadr[k], (k == 0) ? 1 + ($random(seed) & 3) : 0);
			status(s);
			chk(s, exp_status(1'b1, 1'b0));
			chk({7'h00, act}, 8'h01);
			if (k == 0) begin
				read_id();
				chk({7'h00, u_host.drove}, 8'h00);
			end
			s = 8'h01;
			for (int i = 0; i < 20 && s[0] !== 1'b0; i++) status(s);
			chk(s, 8'h00);
			chk({7'h00, act}, 8'h00);
			$display("test self-timed op %0d done", k);
		end
		op(sfp_pkg::OP_WR_ENABLE, 0, 0);
		u_host.open_frame();
		repeat (5) tx(8'($random(seed)) & 8'h02 | 8'h02);
		u_host.xfer(8'h00, 3, a);
		u_host.close_frame();
		status(s);
		chk(s & 8'h01, 8'h00);
		$display("test aborted program done");
		close_out();
	end
endmodule : tb_sfp_flash
`default_nettype wire
